// ==== shared/sdram_ctrl_defs.vh ====
// Constants for the SDRAM mode, refresh and power control block
`ifndef SDRAM_CTRL_DEFS_VH
`define SDRAM_CTRL_DEFS_VH

// ****************************************
// Mode register field positions
// ****************************************
`define MODE_W 15
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_ORDER_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define MODE_TEST_BIT 7
`define MODE_SWRITE_BIT 9
`define MODE_RESET 15'h0000
`define MODE_RSVD_MASK 15'h7D00

// ****************************************
// Field encodings
// ****************************************
`define BL_ONE 3'h1
`define BL_CODE_1 3'h0
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_CODE_FULL 3'h7
`define CL_CODE_2 3'h2
`define CL_CODE_3 3'h3

// ****************************************
// Command codes {csN, rasN, casN, weN}
// ****************************************
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
`define CMD_BST 4'h6

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 20
`define SELF_REFI_NS 7800
`define SELF_REFI_CYC (`SELF_REFI_NS / `CLK_PERIOD_NS)
`define REFRESH_ROWS 8192

`endif

// ==== verilog/burst_addr_gen.v ====
// Burst column address generator for linear and interleaved order
`timescale 1ns/10ps
`default_nettype none
`include "sdram_ctrl_defs.vh"

module burst_addr_gen #(
   parameter COL_W = 9
) (
   input wire [COL_W-1:0] startCol,
   input wire [COL_W-1:0] beatIdx,
   input wire [2:0] lenCode,
   input wire interleave,
   output reg [COL_W-1:0] beatCol
);

   reg [COL_W-1:0] wrapMask;
   reg [COL_W-1:0] linSum;

   always @* begin
      wrapMask = {COL_W{1'b0}};
      linSum = startCol + beatIdx;
      case (lenCode)
         `BL_CODE_2: wrapMask = {{(COL_W-1){1'b0}}, 1'b1};
         `BL_CODE_4: wrapMask = {{(COL_W-2){1'b0}}, 2'b11};
         `BL_CODE_8: wrapMask = {{(COL_W-3){1'b0}}, 3'b111};
         `BL_CODE_FULL: wrapMask = {COL_W{1'b1}};
         default: wrapMask = {COL_W{1'b0}};
      endcase
      if (interleave && lenCode != `BL_CODE_FULL) begin
         beatCol = startCol ^ (beatIdx & wrapMask);
      end else begin
         beatCol = (linSum & wrapMask) | (startCol & ~wrapMask);
      end
   end

endmodule // burst_addr_gen

`default_nettype wire

// ==== verilog/sdram_mode_refresh_power_ctrl.v ====
// Command-side control: mode register, refresh, power-down, suspend, DQM
`timescale 1ns/10ps
`default_nettype none
`include "sdram_ctrl_defs.vh"

// Notes on behaviour
// - Mode loaded by mode-set only when idle
// - Low three bits select burst length
// - Bit three picks linear or interleaved order
// - Burst columns wrap inside burst bits
// - Bits six to four set read latency
// - Bit nine forces single-word writes
// - Auto refresh when idle, internal row counter
// - Refresh with gate low enters self refresh
// - Self refresh shuts all buffers but gate
// - Gate low when idle enters power-down
// - Gate low in burst freezes next cycle
// - Mask during read disables output two later
// - Mask during write drops that cycle's data
module sdram_mode_refresh_power_ctrl #(
   parameter COL_W = 9,
   parameter ROW_W = 13,
   parameter SELF_REFI_CYC = `SELF_REFI_CYC
) (
   input wire core_clk,
   input wire srst,
   input wire cke,
   input wire csN,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire [12:0] addr,
   input wire [1:0] bankSel,
   input wire dqm,
   output reg [`MODE_W-1:0] modeReg_r,
   output reg modeIllegal_r,
   output reg [COL_W-1:0] colAddr_r,
   output reg rdDriveEn_r,
   output reg wrStrobe_r,
   output reg burstActive_r,
   output reg clkSuspended_r,
   output reg refreshStrobe_r,
   output reg [ROW_W-1:0] refreshRow_r,
   output reg selfRefresh_r,
   output reg powerDown_r,
   output reg bufEnable_r
);

   // ****************************************
   // States and helpers
   // ****************************************
   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_RDLAT = 6'b000010;
   localparam [5:0] ST_RDDATA = 6'b000100;
   localparam [5:0] ST_WRDATA = 6'b001000;
   localparam [5:0] ST_SELF = 6'b010000;
   localparam [5:0] ST_PWRDN = 6'b100000;
   // Interval end kept to the counter width on purpose
   localparam [31:0] REFI_SPAN = SELF_REFI_CYC - 1;
   localparam [11:0] REFI_LAST = REFI_SPAN[11:0];

   // Beats per burst; zero means open-ended full page
   function [COL_W:0] beatCount;
      input [2:0] code;
      begin
         case (code)
            `BL_CODE_1: beatCount = {{(COL_W-3){1'b0}}, 4'h1};
            `BL_CODE_2: beatCount = {{(COL_W-3){1'b0}}, 4'h2};
            `BL_CODE_4: beatCount = {{(COL_W-3){1'b0}}, 4'h4};
            `BL_CODE_8: beatCount = {{(COL_W-3){1'b0}}, 4'h8};
            default: beatCount = {(COL_W+1){1'b0}};
         endcase
      end
   endfunction

   // Unlisted length or latency codes, test bit or reserved bits set
   function isIllegal;
      input [`MODE_W-1:0] m;
      reg badBl;
      reg badCl;
      begin
         badBl = (m[`MODE_BL_MSB:`MODE_BL_LSB] > `BL_CODE_8) &&
            (m[`MODE_BL_MSB:`MODE_BL_LSB] != `BL_CODE_FULL);
         badCl = (m[`MODE_CL_MSB:`MODE_CL_LSB] != `CL_CODE_2) &&
            (m[`MODE_CL_MSB:`MODE_CL_LSB] != `CL_CODE_3);
         isIllegal = badBl | badCl | m[`MODE_TEST_BIT] | (|(m & `MODE_RSVD_MASK));
      end
   endfunction

   reg [5:0] state_r;
   reg ckePrev_r;
   reg dqmD1_r;
   reg modeValid_r;
   reg [1:0] latCnt_r;
   reg [COL_W-1:0] startCol_r;
   reg [COL_W-1:0] beatIdx_r;
   reg [COL_W:0] beatsLeft_r;
   reg fullPage_r;
   reg [11:0] refiCnt_r;
   wire [3:0] cmd;
   wire active;
   wire [COL_W-1:0] beatCol;
   wire [2:0] blCode;
   wire [COL_W:0] rdBeats;
   wire [COL_W:0] wrBeats;
   wire lastBeat;
   wire readDone;

   assign cmd = {csN, rasN, casN, weN};
   assign active = ckePrev_r;
   assign blCode = modeReg_r[`MODE_BL_MSB:`MODE_BL_LSB];
   assign rdBeats = beatCount(blCode);
   assign wrBeats = modeReg_r[`MODE_SWRITE_BIT] ? {{(COL_W-2){1'b0}}, `BL_ONE} : rdBeats;
   assign lastBeat = !fullPage_r && (beatsLeft_r == 1);
   // Read ends only after the final beat has been shown
   assign readDone = !fullPage_r && (beatsLeft_r == {(COL_W+1){1'b0}});

   burst_addr_gen #(
      .COL_W(COL_W)
   ) u_addr (
      .startCol(startCol_r),
      .beatIdx(beatIdx_r),
      .lenCode(blCode),
      .interleave(modeReg_r[`MODE_ORDER_BIT]),
      .beatCol(beatCol)
   );

   // ****************************************
   // Main command and burst sequencer
   // ****************************************
   always @(posedge core_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         ckePrev_r <= 1'b1;
         dqmD1_r <= 1'b0;
         modeValid_r <= 1'b0;
         modeReg_r <= `MODE_RESET;
         modeIllegal_r <= 1'b1;
         latCnt_r <= 2'h0;
         startCol_r <= {COL_W{1'b0}};
         beatIdx_r <= {COL_W{1'b0}};
         beatsLeft_r <= {(COL_W+1){1'b0}};
         fullPage_r <= 1'b0;
         colAddr_r <= {COL_W{1'b0}};
         rdDriveEn_r <= 1'b0;
         wrStrobe_r <= 1'b0;
         burstActive_r <= 1'b0;
         clkSuspended_r <= 1'b0;
         refreshStrobe_r <= 1'b0;
         refreshRow_r <= {ROW_W{1'b0}};
         refiCnt_r <= 12'h000;
         selfRefresh_r <= 1'b0;
         powerDown_r <= 1'b0;
         bufEnable_r <= 1'b1;
      end else begin
         ckePrev_r <= cke;
         dqmD1_r <= dqm;
         refreshStrobe_r <= 1'b0;
         wrStrobe_r <= 1'b0;
         clkSuspended_r <= !cke && !state_r[0] && !state_r[4] && !state_r[5];
         case (state_r)
            ST_IDLE: begin
               rdDriveEn_r <= 1'b0;
               burstActive_r <= 1'b0;
               if (active) begin
                  if (cmd == `CMD_REF && !cke) begin
                     state_r <= ST_SELF;
                     selfRefresh_r <= 1'b1;
                     bufEnable_r <= 1'b0;
                     refiCnt_r <= 12'h000;
                  end else if (cmd == `CMD_REF) begin
                     refreshStrobe_r <= 1'b1;
                     refreshRow_r <= refreshRow_r + 1'b1;
                  end else if (!cke) begin
                     state_r <= ST_PWRDN;
                     powerDown_r <= 1'b1;
                     bufEnable_r <= 1'b0;
                  end else if (cmd == `CMD_MRS) begin
                     modeReg_r <= {bankSel, addr};
                     modeValid_r <= 1'b1;
                     modeIllegal_r <= isIllegal({bankSel, addr});
                  end else if (cmd == `CMD_RD && modeValid_r) begin
                     latCnt_r <= modeReg_r[`MODE_CL_LSB] ? 2'h1 : 2'h0;
                     startCol_r <= addr[COL_W-1:0];
                     fullPage_r <= (rdBeats == 0);
                     beatsLeft_r <= rdBeats;
                     beatIdx_r <= {COL_W{1'b0}};
                     burstActive_r <= 1'b1;
                     state_r <= ST_RDLAT;
                  end else if (cmd == `CMD_WR && modeValid_r) begin
                     startCol_r <= addr[COL_W-1:0];
                     colAddr_r <= addr[COL_W-1:0];
                     wrStrobe_r <= !dqm;
                     beatIdx_r <= {{(COL_W-1){1'b0}}, 1'b1};
                     fullPage_r <= (wrBeats == 0);
                     beatsLeft_r <= wrBeats - 1'b1;
                     if (wrBeats != 1) begin
                        burstActive_r <= 1'b1;
                        state_r <= ST_WRDATA;
                     end
                  end
               end
            end
            ST_RDLAT: begin
               if (active) begin
                  if (cmd == `CMD_BST || cmd == `CMD_PRE) begin
                     state_r <= ST_IDLE;
                     burstActive_r <= 1'b0;
                  end else if (latCnt_r != 0) begin
                     latCnt_r <= latCnt_r - 1'b1;
                  end else begin
                     // First beat lands at the latency edge
                     colAddr_r <= beatCol;
                     beatIdx_r <= beatIdx_r + 1'b1;
                     beatsLeft_r <= beatsLeft_r - 1'b1;
                     rdDriveEn_r <= !dqmD1_r;
                     state_r <= ST_RDDATA;
                  end
               end
            end
            ST_RDDATA: begin
               if (active) begin
                  if (readDone || cmd == `CMD_BST || cmd == `CMD_PRE) begin
                     rdDriveEn_r <= 1'b0;
                     burstActive_r <= 1'b0;
                     state_r <= ST_IDLE;
                  end else begin
                     colAddr_r <= beatCol;
                     beatIdx_r <= beatIdx_r + 1'b1;
                     beatsLeft_r <= beatsLeft_r - 1'b1;
                     // output off two edges after mask
                     rdDriveEn_r <= !dqmD1_r;
                  end
               end
            end
            ST_WRDATA: begin
               if (active) begin
                  if (cmd == `CMD_BST || cmd == `CMD_PRE) begin
                     burstActive_r <= 1'b0;
                     state_r <= ST_IDLE;
                  end else begin
                     colAddr_r <= beatCol;
                     wrStrobe_r <= !dqm;
                     beatIdx_r <= beatIdx_r + 1'b1;
                     beatsLeft_r <= beatsLeft_r - 1'b1;
                     if (lastBeat) begin
                        burstActive_r <= 1'b0;
                        state_r <= ST_IDLE;
                     end
                  end
               end
            end
            ST_SELF: begin
               if (cke) begin
                  state_r <= ST_IDLE;
                  selfRefresh_r <= 1'b0;
                  bufEnable_r <= 1'b1;
               end else if (refiCnt_r == REFI_LAST) begin
                  // Internal timer refreshes the next row
                  refiCnt_r <= 12'h000;
                  refreshStrobe_r <= 1'b1;
                  refreshRow_r <= refreshRow_r + 1'b1;
               end else begin
                  refiCnt_r <= refiCnt_r + 1'b1;
               end
            end
            ST_PWRDN: begin
               if (cke) begin
                  state_r <= ST_IDLE;
                  powerDown_r <= 1'b0;
                  bufEnable_r <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // sdram_mode_refresh_power_ctrl

`default_nettype wire

// ==== bench/sdram_ctrl_assertions.sv ====
// Port checks for the SDRAM mode, refresh and power control block
`timescale 1ns/10ps
`default_nettype none
`include "sdram_ctrl_defs.vh"

module sdram_ctrl_assertions #(
   parameter COL_W = 9,
   parameter ROW_W = 13
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [12:0] addr,
   input wire logic [1:0] bankSel,
   input wire logic dqm,
   input wire logic [`MODE_W-1:0] modeReg_r,
   input wire logic modeIllegal_r,
   input wire logic [COL_W-1:0] colAddr_r,
   input wire logic rdDriveEn_r,
   input wire logic wrStrobe_r,
   input wire logic burstActive_r,
   input wire logic clkSuspended_r,
   input wire logic refreshStrobe_r,
   input wire logic [ROW_W-1:0] refreshRow_r,
   input wire logic selfRefresh_r,
   input wire logic powerDown_r,
   input wire logic bufEnable_r
);
   logic ckeP_r;
   // Command decode and idle state as the block sees it
   wire logic [3:0] cmd = {csN, rasN, casN, weN};
   wire logic idleNow = ckeP_r && !burstActive_r && !selfRefresh_r && !powerDown_r;
   wire logic [2:0] bl = modeReg_r[2:0];
   wire logic [2:0] cl = modeReg_r[6:4];
   wire logic badMode = (bl[2] && bl != `BL_CODE_FULL) || (cl != `CL_CODE_2 && cl != `CL_CODE_3)
      || modeReg_r[`MODE_TEST_BIT] || |(modeReg_r & `MODE_RSVD_MASK);
   // Gate level at the previous edge, high through reset
   always_ff @(posedge core_clk) ckeP_r <= srst || cke;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   chk_mode_load: assert property (idleNow && cke && cmd == `CMD_MRS
      |=> modeReg_r == $past({bankSel, addr})) else $error("mode value not loaded");
   chk_mode_flag: assert property (modeIllegal_r == badMode)
      else $error("mode legality flag wrong");
   chk_auto_ref: assert property (idleNow && cke && cmd == `CMD_REF
      |=> refreshStrobe_r && !selfRefresh_r) else $error("auto refresh missing");
   chk_self_entry: assert property (idleNow && !cke && cmd == `CMD_REF
      |=> selfRefresh_r) else $error("self refresh not entered");
   chk_bufs_off: assert property (selfRefresh_r || powerDown_r |-> !bufEnable_r)
      else $error("buffers left on");
   chk_pd_entry: assert property (idleNow && !cke && cmd != `CMD_REF |=> powerDown_r)
      else $error("power-down not entered");
   chk_read_cl2: assert property (idleNow && cke && cmd == `CMD_RD && !modeIllegal_r
      && cl == `CL_CODE_2 && !dqm ##1 cmd != `CMD_BST && cmd != `CMD_PRE
      |=> rdDriveEn_r && colAddr_r == $past(addr[COL_W-1:0], 2))
      else $error("read latency two broken");
   chk_dqm_read: assert property (ckeP_r && cke && dqm |=> ##1 !rdDriveEn_r)
      else $error("masked read still driven");
   chk_wr_mask: assert property (wrStrobe_r |-> !$past(dqm) && $past(ckeP_r))
      else $error("masked or frozen write taken");
   chk_suspend: assert property (clkSuspended_r |=> $stable(colAddr_r))
      else $error("burst moved while frozen");
endmodule // sdram_ctrl_assertions

bind sdram_mode_refresh_power_ctrl sdram_ctrl_assertions #(.COL_W(COL_W), .ROW_W(ROW_W))
   i_chk (.*);

`default_nettype wire

// ==== bench/mem_ctrl_model.sv ====
// Memory controller stand-in driving commands, gate and mask
`timescale 1ns/10ps
`default_nettype none

module mem_ctrl_model (
   input wire logic core_clk,
   output logic cke,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic [12:0] addr,
   output logic [1:0] bankSel,
   output logic dqm
);
   // Power up with gate high and a no-op on the bus
   initial begin
      cke = 1'b1;
      {csN, rasN, casN, weN} = 4'hF;
      {bankSel, addr} = 15'h0000;
      dqm = 1'b0;
   end
   // Drive one command at the falling edge
   // no auto precharge, no overlapping bursts
   task automatic issue(input logic [3:0] c, input logic [14:0] v, input logic k);
      @(negedge core_clk);
      {csN, rasN, casN, weN} = c;
      {bankSel, addr} = v;
      cke = k;
   endtask
   task automatic idle(input int n, input logic m, input logic k);
      repeat (n) begin
         @(negedge core_clk);
         {csN, rasN, casN, weN} = 4'hF;
         {bankSel, addr} = ~{bankSel, addr}; // Released lines toggle
         dqm = m;
         cke = k;
      end
   endtask
endmodule // mem_ctrl_model

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the SDRAM mode, refresh and power control block
`timescale 1ns/10ps
`default_nettype none
`include "sdram_ctrl_defs.vh"

module testbench;
   localparam int REFI = 8;
   localparam logic [14:0] MODES [10] = '{15'h0020, 15'h0021, 15'h0022, 15'h0023, 15'h0027,
      15'h0024, 15'h0030, 15'h0040, 15'h00A0, 15'h4020};
   localparam logic [9:0] BAD = 10'h3A0;
   logic core_clk, srst, cke, csN, rasN, casN, weN, dqm;
   logic [12:0] addr, refreshRow_r;
   logic [1:0] bankSel;
   logic [14:0] modeReg_r;
   logic [8:0] colAddr_r;
   logic modeIllegal_r, rdDriveEn_r, wrStrobe_r, burstActive_r, clkSuspended_r;
   logic refreshStrobe_r, selfRefresh_r, powerDown_r, bufEnable_r;
   int errors = 0, comparisons = 0, cycles = 0, expRow = 0;

   sdram_mode_refresh_power_ctrl #(.SELF_REFI_CYC(REFI)) i_dut (
      .core_clk(core_clk), .srst(srst), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .addr(addr), .bankSel(bankSel), .dqm(dqm), .modeReg_r(modeReg_r),
      .modeIllegal_r(modeIllegal_r), .colAddr_r(colAddr_r), .rdDriveEn_r(rdDriveEn_r),
      .wrStrobe_r(wrStrobe_r), .burstActive_r(burstActive_r), .clkSuspended_r(clkSuspended_r),
      .refreshStrobe_r(refreshStrobe_r), .refreshRow_r(refreshRow_r),
      .selfRefresh_r(selfRefresh_r), .powerDown_r(powerDown_r), .bufEnable_r(bufEnable_r));
   mem_ctrl_model i_host (.core_clk(core_clk), .cke(cke), .csN(csN), .rasN(rasN),
      .casN(casN), .weN(weN), .addr(addr), .bankSel(bankSel), .dqm(dqm));

   // Free-running 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic check_val(input logic [14:0] got, input logic [14:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Cut a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         wrap_up;
      end
   end
   task automatic set_mode(input logic [14:0] v);
      i_host.issue(`CMD_MRS, v, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
   endtask
   task automatic test_reset;
      check_val(modeReg_r, 15'h0000);
      check_bit(modeIllegal_r, 1'b1);
      i_host.issue(`CMD_RD, 15'h0000, 1'b1);
      i_host.idle(3, 1'b0, 1'b1);
      check_bit(burstActive_r, 1'b0);
      $display("reset test done");
   endtask
   task automatic test_modes;
      for (int i = 0; i < 10; i++) begin
         set_mode(MODES[i]);
         check_val(modeReg_r, MODES[i]);
         check_bit(modeIllegal_r, BAD[i]);
      end
      $display("mode test done");
   endtask
   task automatic test_read(input logic [14:0] mode, input logic [8:0] col, input int bl, cl);
      logic [8:0] m, e;
      m = 9'(bl - 1);
      set_mode(mode);
      i_host.issue(`CMD_RD, {6'h00, col}, 1'b1);
      i_host.idle(cl - 1, 1'b0, 1'b1);
      check_bit(rdDriveEn_r, 1'b0);
      for (int i = 0; i < bl; i++) begin
         e = mode[3] ? col ^ 9'(i) : (col & ~m) | ((col + 9'(i)) & m);
         i_host.idle(1, 1'b0, 1'b1);
         check_bit(rdDriveEn_r, 1'b1);
         check_val(15'(colAddr_r), 15'(e));
      end
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(burstActive_r, 1'b0);
      $display("read test done");
   endtask
   task automatic test_burst_stop;
      set_mode(15'h0027);
      i_host.issue(`CMD_RD, 15'h01FF, 1'b1);
      i_host.idle(4, 1'b0, 1'b1);
      check_val(15'(colAddr_r), 15'h0001);
      i_host.issue(`CMD_BST, 15'h0000, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(burstActive_r, 1'b0);
      check_bit(rdDriveEn_r, 1'b0);
      i_host.issue(`CMD_WR, 15'h0000, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(burstActive_r, 1'b1);
      i_host.issue(`CMD_PRE, 15'h0000, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(burstActive_r, 1'b0);
      $display("burst stop test done");
   endtask
   task automatic test_write;
      set_mode(15'h0221);
      i_host.issue(`CMD_WR, 15'h0005, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(wrStrobe_r, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(wrStrobe_r, 1'b0);
      set_mode(15'h0021);
      i_host.issue(`CMD_WR, 15'h0005, 1'b1);
      i_host.idle(1, 1'b1, 1'b1);
      check_bit(wrStrobe_r, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(wrStrobe_r, 1'b0);
      check_val(15'(colAddr_r), 15'h0004);
      $display("write test done");
   endtask
   task automatic test_dqm_read;
      set_mode(15'h0022);
      i_host.issue(`CMD_RD, 15'h0000, 1'b1);
      i_host.idle(1, 1'b1, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(rdDriveEn_r, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(rdDriveEn_r, 1'b0);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(rdDriveEn_r, 1'b1);
      i_host.idle(3, 1'b0, 1'b1);
      $display("mask test done");
   endtask
   task automatic test_suspend;
      i_host.issue(`CMD_RD, 15'h0000, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      i_host.idle(1, 1'b0, 1'b0);
      i_host.idle(1, 1'b0, 1'b1);
      check_bit(clkSuspended_r, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      check_val(15'(colAddr_r), 15'h0001);
      i_host.idle(1, 1'b0, 1'b1);
      check_val(15'(colAddr_r), 15'h0002);
      i_host.idle(3, 1'b0, 1'b1);
      $display("suspend test done");
   endtask
   task automatic test_refresh;
      int n;
      n = 0;
      i_host.issue(`CMD_REF, 15'h0000, 1'b1);
      i_host.idle(1, 1'b0, 1'b1);
      expRow++;
      check_bit(refreshStrobe_r, 1'b1);
      check_val(15'(refreshRow_r), 15'(expRow));
      i_host.idle(4, 1'b0, 1'b1);
      i_host.issue(`CMD_REF, 15'h0000, 1'b0);
      repeat (2 * REFI + 1) begin
         i_host.idle(1, 1'b0, 1'b0);
         n += refreshStrobe_r;
      end
      check_bit(selfRefresh_r, 1'b1);
      check_bit(bufEnable_r, 1'b0);
      repeat (2) begin
         i_host.idle(1, 1'b0, 1'b1);
         n += refreshStrobe_r;
      end
      check_bit(selfRefresh_r, 1'b0);
      check_bit(n >= 2 && n <= 3, 1'b1);
      expRow += n;
      check_val(15'(refreshRow_r), 15'(expRow));
      $display("refresh test done");
   endtask
   task automatic test_power_down;
      set_mode(15'h0022);
      i_host.idle(2, 1'b0, 1'b0);
      check_bit(powerDown_r, 1'b1);
      check_bit(bufEnable_r, 1'b0);
      i_host.issue(`CMD_MRS, 15'h0023, 1'b0);
      i_host.idle(2, 1'b0, 1'b1);
      check_bit(powerDown_r, 1'b0);
      check_val(modeReg_r, 15'h0022);
      $display("power-down test done");
   endtask
   // Reset for ten cycles, then run every scenario
   initial begin
      srst = 1'b1;
      repeat (10) @(negedge core_clk);
      srst = 1'b0;
      test_reset;
      test_modes;
      test_read(15'h0022, 9'h00D, 4, 2);
      test_read(15'h002B, 9'h00D, 8, 2);
      test_read(15'h0031, 9'h007, 2, 3);
      test_burst_stop;
      test_write;
      test_dqm_read;
      test_suspend;
      test_refresh;
      test_power_down;
      wrap_up;
   end
endmodule // testbench

`default_nettype wire
